// ===== rtl/osc_ctrl.v
// Purpose: oscillator control and status registers
// Assumes: one-cycle read and write strobes from the core's register space
// Notes: analog oscillators are outside; this block steers and observes them
`timescale 1ns/1ps
`include "osc_defines.vh"

module osc_ctrl #(
	parameter [6:0] TRIM_RESET = 7'h40
)(
	input wire ref_clk,
	input wire resetn,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire int_osc_settled,
	input wire ext_osc_stable,
	output reg internal_osc_enable,
	output reg dither_enable,
	output reg [6:0] internal_osc_trim_value,
	output reg [2:0] external_mode_select,
	output reg [2:0] external_bias_level,
	output reg ext_circuit_on,
	output reg ext_div2_on
);

//------------------------------------------------------------
// register state
//------------------------------------------------------------
// reserved low bits of the internal control byte, kept as written
reg [5:0] int_rsvd_q;
reg [5:0] int_rsvd_d;
// frequency ready flag and its next value
reg ready_q;
reg ready_d;
// set once the factory trim has been taken after reset
reg trim_loaded_q;
reg trim_loaded_d;
// next values of the registered outputs
reg int_en_d;
reg dither_d;
reg [6:0] trim_d;
reg [2:0] mode_d;
reg [2:0] bias_d;
reg circuit_d;
reg div2_d;
reg [7:0] rdata_d;

//------------------------------------------------------------
// address decode
//------------------------------------------------------------
wire wr_ext;
wire wr_int;
wire wr_trim;
wire [2:0] wmode;
wire ext_cmos;
wire ext_valid;

// one write strobe per register
assign wr_ext = reg_wr && (reg_addr == `OSC_ADDR_EXT_CTRL);
assign wr_int = reg_wr && (reg_addr == `OSC_ADDR_INT_CTRL);
assign wr_trim = reg_wr && (reg_addr == `OSC_ADDR_INT_TRIM);
// mode field of the byte being written
assign wmode = reg_wdata[`OSC_MODE_MSB:`OSC_MODE_LSB];

// cmos clock input modes, plain and halved
assign ext_cmos = (external_mode_select == `OSC_MODE_CMOS) ||
	(external_mode_select == `OSC_MODE_CMOS_DIV2);

// valid only when running, never in cmos modes
assign ext_valid = ext_osc_stable && ext_circuit_on &&
	!ext_cmos;

//------------------------------------------------------------
// internal oscillator control
//------------------------------------------------------------
// enable and reserved bits follow each write
always @*
begin
	int_en_d = internal_osc_enable;
	int_rsvd_d = int_rsvd_q;
	if (wr_int)
	begin
		int_en_d = reg_wdata[`OSC_BIT_INT_EN];
		int_rsvd_d = reg_wdata[5:0];
	end
end

// ready drops on any internal control write or when stopped, rises on settle
always @*
begin
	ready_d = ready_q;
	if (!internal_osc_enable || wr_int)
		ready_d = 1'b0;
	else if (int_osc_settled)
		ready_d = 1'b1;
end

// registers of the internal control byte
always @(posedge ref_clk or negedge resetn)
begin
	if (!resetn)
	begin
		internal_osc_enable <= 1'b0;
		int_rsvd_q <= `OSC_INT_RSVD_RST;
		ready_q <= 1'b0;
	end
	else
	begin
		internal_osc_enable <= int_en_d;
		int_rsvd_q <= int_rsvd_d;
		ready_q <= ready_d;
	end
end

//------------------------------------------------------------
// trim and dithering
//------------------------------------------------------------
// factory trim is taken on the first edge after release
always @*
begin
	trim_loaded_d = 1'b1;
	dither_d = dither_enable;
	trim_d = internal_osc_trim_value;
	if (!trim_loaded_q)
		trim_d = TRIM_RESET;
	else if (wr_trim)
		trim_d = reg_wdata[6:0];
	if (wr_trim)
		dither_d = reg_wdata[`OSC_BIT_DITHER];
end

// the trim field of a write in the load cycle loses to the factory value; its dither bit is still taken
always @(posedge ref_clk or negedge resetn)
begin
	if (!resetn)
	begin
		trim_loaded_q <= 1'b0;
		dither_enable <= 1'b0;
		internal_osc_trim_value <= `OSC_TRIM_PRELOAD;
	end
	else
	begin
		trim_loaded_q <= trim_loaded_d;
		dither_enable <= dither_d;
		internal_osc_trim_value <= trim_d;
	end
end

//------------------------------------------------------------
// external oscillator control
//------------------------------------------------------------
// mode, bias and circuit steering follow each write
always @*
begin
	mode_d = external_mode_select;
	bias_d = external_bias_level;
	circuit_d = ext_circuit_on;
	div2_d = ext_div2_on;
	if (wr_ext)
	begin
		mode_d = wmode;
		bias_d = reg_wdata[`OSC_BIAS_MSB:`OSC_BIAS_LSB];
		circuit_d = wmode[2] | wmode[1];
		div2_d = (wmode == `OSC_MODE_CMOS_DIV2) ||
			(wmode == `OSC_MODE_XTAL_DIV2);
	end
end

// registers of the external control byte
always @(posedge ref_clk or negedge resetn)
begin
	if (!resetn)
	begin
		external_mode_select <= `OSC_MODE_RST;
		external_bias_level <= `OSC_BIAS_RST;
		ext_circuit_on <= 1'b0;
		ext_div2_on <= 1'b0;
	end
	else
	begin
		external_mode_select <= mode_d;
		external_bias_level <= bias_d;
		ext_circuit_on <= circuit_d;
		ext_div2_on <= div2_d;
	end
end

//------------------------------------------------------------
// read path
//------------------------------------------------------------
// read mux; bit 3 of the external byte always reads 0
always @*
begin
	rdata_d = reg_rdata;
	if (reg_rd)
	begin
		case (reg_addr)
		`OSC_ADDR_EXT_CTRL:
			rdata_d = {ext_valid, external_mode_select, 1'b0,
				external_bias_level};
		`OSC_ADDR_INT_CTRL:
			rdata_d = {internal_osc_enable, ready_q,
				int_rsvd_q};
		`OSC_ADDR_INT_TRIM:
			rdata_d = {dither_enable, internal_osc_trim_value};
		default:
			rdata_d = 8'h00;
		endcase
	end
end

// read data holds until the next read
always @(posedge ref_clk or negedge resetn)
begin
	if (!resetn)
		reg_rdata <= `OSC_RDATA_RST;
	else
		reg_rdata <= rdata_d;
end

endmodule // osc_ctrl

// ===== rtl/osc_defines.vh
// Purpose: constants for the oscillator control registers
// Assumes: 8-bit special-function register space, byte addresses
// Notes: trim reset value is a per-part factory value, given at elaboration
// What this block does
// - internal oscillator runs while enable bit 7 is 1; resets to 0
// - bit 6 ready flag reads 1 only while oscillator at programmed rate
// - trim bit 7 set turns on spread-spectrum dithering of internal clock
// - seven-bit trim field comes up at factory value for 24.5 MHz
// - larger trim lowers frequency, smaller raises; about one percent a step
// - external valid flag bit 7 reads 1 when external oscillator stable
// - valid flag always reads 0 in both CMOS clock modes
// - mode bits 6:4: 00x disabled, 010 CMOS, 011 CMOS divided by two
// - mode 100 RC, 101 capacitor, 110 crystal, 111 crystal divided by two
// - external control bit 3 reads 0; software writes 0
// - bits 2:0 select one of eight external bias current levels
`ifndef OSC_DEFINES_VH
`define OSC_DEFINES_VH
`define OSC_ADDR_EXT_CTRL 8'hB1
`define OSC_ADDR_INT_CTRL 8'hB2
`define OSC_ADDR_INT_TRIM 8'hB3
`define OSC_EXT_CTRL_RST 8'h00
`define OSC_INT_RSVD_RST 6'h00
`define OSC_TRIM_PRELOAD 7'h00
`define OSC_MODE_RST 3'h0
`define OSC_BIAS_RST 3'h0
`define OSC_RDATA_RST 8'h00
`define OSC_BIT_INT_EN 7
`define OSC_BIT_INT_RDY 6
`define OSC_BIT_DITHER 7
`define OSC_BIT_EXT_VALID 7
`define OSC_MODE_MSB 6
`define OSC_MODE_LSB 4
`define OSC_BIAS_MSB 2
`define OSC_BIAS_LSB 0
`define OSC_MODE_OFF0 3'h0
`define OSC_MODE_OFF1 3'h1
`define OSC_MODE_CMOS 3'h2
`define OSC_MODE_CMOS_DIV2 3'h3
`define OSC_MODE_RC 3'h4
`define OSC_MODE_CAP 3'h5
`define OSC_MODE_XTAL 3'h6
`define OSC_MODE_XTAL_DIV2 3'h7
`endif

// ===== test/osc_ctrl_asserts.sv
// Purpose: port checks; Assumes: one clock; Notes: bound in bench
`timescale 1ns/1ps
module osc_ctrl_asserts #(parameter [6:0] TRIM_RESET = 7'h40) (
	input wire ref_clk, resetn, reg_wr, reg_rd, internal_osc_enable,
	input wire dither_enable, ext_circuit_on, ext_div2_on,
	input wire [7:0] reg_addr, reg_wdata, reg_rdata,
	input wire [6:0] internal_osc_trim_value,
	input wire [2:0] external_mode_select);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	property p_en; reg_wr && reg_addr == 8'hB2 |=>
		internal_osc_enable == $past(reg_wdata[7]); endproperty
	a_en: assert property (p_en) else $error("enable");
	property p_tr; reg_wr && reg_addr == 8'hB3 |=>
		{dither_enable, internal_osc_trim_value} == $past(reg_wdata);
	endproperty
	a_tr: assert property (p_tr) else $error("trim");
	property p_md; reg_wr && reg_addr == 8'hB1 |=>
		external_mode_select == $past(reg_wdata[6:4]); endproperty
	a_md: assert property (p_md) else $error("mode");
	property p_on; ext_circuit_on == |external_mode_select[2:1]; endproperty
	a_on: assert property (p_on) else $error("circuit");
	property p_dv; ext_div2_on == &external_mode_select[1:0]; endproperty
	a_dv: assert property (p_dv) else $error("divider");
	property p_rd; reg_rd && reg_addr == 8'hB2 && !internal_osc_enable
		|=> !reg_rdata[6]; endproperty
	a_rd: assert property (p_rd) else $error("ready");
	property p_vl; reg_rd && reg_addr == 8'hB1 && !external_mode_select[2]
		|=> !reg_rdata[7] && !reg_rdata[3]; endproperty
	a_vl: assert property (p_vl) else $error("valid");
	property p_rs; $rose(resetn) |=> internal_osc_trim_value == TRIM_RESET;
	endproperty
	a_rs: assert property (p_rs) else $error("trim reset");
endmodule // osc_ctrl_asserts

// ===== test/osc_src.sv
// Purpose: clock source model; Assumes: one clock; Notes: settles in one edge
`timescale 1ns/1ps
module osc_src (
	input wire ref_clk, ext_circuit_on, internal_osc_enable,
	output reg ext_osc_stable, int_osc_settled);
	// detectors report one edge after start, drop one edge after stop
	always @(posedge ref_clk)
		{ext_osc_stable, int_osc_settled} <= {ext_circuit_on, internal_osc_enable};
endmodule // osc_src

// ===== test/test_osc_ctrl.sv
// Purpose: bench; Assumes: 10 MHz clock; Notes: drives on falling edge
`timescale 1ns/1ps
module test_osc_ctrl;
	reg ref_clk = 1'h0, resetn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
	reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	wire [7:0] reg_rdata;
	wire [6:0] internal_osc_trim_value;
	wire [2:0] external_mode_select, external_bias_level;
	wire int_osc_settled, ext_osc_stable, internal_osc_enable, dither_enable;
	wire ext_circuit_on, ext_div2_on;
	integer error_cnt = 0, tests_run = 0, m;
	osc_ctrl #(.TRIM_RESET(7'h35)) osc_ctrl_i (.ref_clk(ref_clk),
		.resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.int_osc_settled(int_osc_settled), .ext_osc_stable(ext_osc_stable),
		.internal_osc_enable(internal_osc_enable),
		.dither_enable(dither_enable),
		.internal_osc_trim_value(internal_osc_trim_value),
		.external_mode_select(external_mode_select),
		.external_bias_level(external_bias_level),
		.ext_circuit_on(ext_circuit_on), .ext_div2_on(ext_div2_on));
	osc_src osc_src_i (.ref_clk(ref_clk), .ext_circuit_on(ext_circuit_on),
		.internal_osc_enable(internal_osc_enable),
		.ext_osc_stable(ext_osc_stable), .int_osc_settled(int_osc_settled));
	initial forever #50 ref_clk = ~ref_clk;
	// one register access; a read compares against d
	task acc(input w, input [7:0] a, d);
	begin
		@(negedge ref_clk) {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
		@(negedge ref_clk) {reg_wr, reg_rd} = 2'h0;
		tests_run = tests_run + !w;
		if (!w && reg_rdata !== d)
		begin
			error_cnt = error_cnt + 1;
			$display("ERROR %0t read %h", $time, reg_rdata);
		end
	end
	endtask
	// reset values, internal oscillator, trim, unmapped place
	task t_int;
	begin
		acc(0, 8'hB2, 8'h00);
		acc(0, 8'hB3, 8'h35);
		acc(1, 8'hB2, 8'hAA);
		acc(0, 8'hB2, 8'hAA);
		acc(0, 8'hB2, 8'hEA);
		acc(1, 8'hB2, 8'h2A);
		acc(0, 8'hB2, 8'h2A);
		acc(1, 8'hB3, 8'hFF);
		acc(1, 8'hC0, 8'h00);
		acc(0, 8'hB3, 8'hFF);
		acc(0, 8'hC0, 8'h00);
		acc(1, 8'hB3, 8'h36);
		acc(0, 8'hB3, 8'h36);
	end
	endtask
	// every external mode with its own bias level
	task t_ext;
	begin
		for (m = 0; m < 8; m = m + 1)
		begin
			acc(1, 8'hB1, {1'h0, m[2:0], 1'h0, m[2:0]});
			acc(0, 8'hB1, {m[2], m[2:0], 1'h0, m[2:0]});
		end
	end
	endtask
	task summarize;
	begin
		if (error_cnt == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	// reset for six cycles, then the scenarios
	initial
	begin
		repeat (6) @(negedge ref_clk);
		resetn = 1'h1;
		@(negedge ref_clk);
		t_int;
		t_ext;
		summarize;
	end
endmodule // test_osc_ctrl
bind osc_ctrl osc_ctrl_asserts #(.TRIM_RESET(TRIM_RESET))
	osc_ctrl_asserts_i (.ref_clk(ref_clk), .resetn(resetn),
	.reg_wr(reg_wr), .reg_rd(reg_rd),
	.internal_osc_enable(internal_osc_enable),
	.dither_enable(dither_enable), .ext_circuit_on(ext_circuit_on),
	.ext_div2_on(ext_div2_on), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.internal_osc_trim_value(internal_osc_trim_value),
	.external_mode_select(external_mode_select));
